// ### bench/dioe_host_model.sv
// Host that services the interrupt lines by counting their assertions
`timescale 1ns/1ps
module dioe_host_model (
    input wire logic sys_clk,
    input wire logic int_x,
    input wire logic int_y,
    output int       x_seen,
    output int       y_seen
);
    logic x_q = 1'b0;
    logic y_q = 1'b0;
    initial x_seen = 0;
    initial y_seen = 0;
    always @(posedge sys_clk) begin
        x_q <= int_x;
        y_q <= int_y;
        x_seen <= x_seen + int'(int_x && !x_q);
        y_seen <= y_seen + int'(int_y && !y_q);
    end
endmodule

// ### bench/dioe_irq_router_properties.sv
// Port-level checks for the interrupt router
`timescale 1ns/1ps
module dioe_irq_router_properties (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [11:0] slot_ready_set,
    input wire logic        int_x,
    input wire logic        int_y
);
    localparam logic [7:0] AY = dioe_pkg::OFF_Y_SLOT_FIFO_MASK;
    localparam logic [7:0] AL = dioe_pkg::OFF_X_LOW_LEVEL_MASK;
    wire rd_go = clk_en && reg_rd && !reg_wr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_fill(logic [7:0] a);
        clk_en && reg_wr && reg_addr == a && reg_wdata == 16'hffff ##1 rd_go && reg_addr == a;
    endsequence
    // Mask write, event, then one cycle for the registered output
    sequence s_arm;
        clk_en && reg_wr && reg_addr == AY && reg_wdata[0]
            ##1 clk_en && slot_ready_set[0] && !reg_wr ##1 clk_en;
    endsequence
    a_reset_quiet: assert property ($rose(reset_n) |->
        !int_x && !int_y && reg_rdata == 16'h0000)
        else $error("outputs not idle after reset");
    a_y_reserved: assert property (rd_go && reg_addr == AY |=> !reg_rdata[12])
        else $error("y mask bit 12 reads one");
    a_xl_reserved: assert property (rd_go && reg_addr == AL |=>
        reg_rdata[15:12] == 4'h0)
        else $error("x low mask top bits read nonzero");
    a_rdata_hold: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_y_fill: assert property (s_fill(AY) |=> reg_rdata == 16'hefff)
        else $error("y mask readback wrong");
    a_xl_fill: assert property (s_fill(AL) |=> reg_rdata == 16'h0fff)
        else $error("x low mask readback wrong");
    a_y_route: assert property (s_arm |=> int_y)
        else $error("enabled slot event missed on y");
    a_rise_enabled: assert property ($rose(int_x) || $rose(int_y) |-> $past(clk_en))
        else $error("interrupt rose while frozen");
endmodule
bind dioe_irq_router dioe_irq_router_properties chk_u (.sys_clk, .reset_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slot_ready_set, .int_x, .int_y);

// ### bench/dioe_irq_router_tb.sv
// Self-checking bench for the interrupt router
`timescale 1ns/1ps
module dioe_irq_router_tb;
    logic        sys_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        fifo_threshold_set = 1'b0, fifo_underrun_set = 1'b0, fifo_overrun_set = 1'b0;
    logic        fifo_read = 1'b0, int_x, int_y;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic [11:0] slot_ready_set = 12'h000, slot_low_level_set = 12'h000;
    int          x_seen, y_seen, fails = 0, n_tests = 0;
    int          bits [5] = '{15, 14, 13, 11, 0};
    logic [7:0]  rmap [4] = '{8'h14, 8'h15, 8'h16, 8'h07};
    logic [39:0] rows [5] = '{{8'h15, 16'hffff, 16'hefff}, {8'h16, 16'hffff, 16'h0fff},
        {8'h14, 16'h000f, 16'h000f}, {8'h15, 16'h1000, 16'h0000}, {8'h30, 16'hffff, 16'h0000}};
    always #5 sys_clk = ~sys_clk;
    dioe_irq_router dut_u (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .slot_ready_set, .slot_low_level_set, .fifo_threshold_set,
        .fifo_underrun_set, .fifo_overrun_set, .fifo_read, .int_x, .int_y);
    dioe_host_model host_u (.sys_clk, .int_x, .int_y, .x_seen, .y_seen);
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t reg %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t irq %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Callers enter on a falling edge, so strobes land one cycle each
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        {reg_addr, reg_rd} = {a, 1'b1};
        tick(1);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic ev(input int b);
        {fifo_threshold_set, fifo_underrun_set, fifo_overrun_set} = {b == 15, b == 14, b == 13};
        slot_ready_set = (b < 12) ? 12'h001 << b : 12'h000;
        tick(1);
        {fifo_threshold_set, fifo_underrun_set, fifo_overrun_set, slot_ready_set} = 15'h0000;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        tick(4);
        reset_n = 1'b1;
        foreach (rmap[i]) begin
            rd(rmap[i]);
            chk_reg(d, (i == 3) ? 16'h8000 : 16'h0000);
            tick(1);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32]);
            chk_reg(d, rows[i][15:0]);
        end
        $display("test rows done");
        foreach (bits[i]) begin
            wr(8'h15, 16'h0000);
            ev(bits[i]);
            tick(2);
            chk_irq(int_y, 1'b0);
            wr(8'h15, 16'h0001 << bits[i]);
            tick(2);
            chk_irq(int_y, 1'b1);
            wr(8'h00, 16'hffff);
            tick(2);
            chk_irq(int_y, 1'b0);
        end
        wr(8'h15, 16'h8001);
        ev(0);
        tick(2);
        chk_irq(int_y, 1'b1);
        wr(8'h00, 16'h0fff);
        ev(15);
        tick(2);
        chk_irq(int_y, 1'b1);
        fifo_read = 1'b1;
        tick(1);
        fifo_read = 1'b0;
        tick(2);
        chk_irq(int_y, 1'b0);
        $display("test y done");
        wr(8'h14, 16'h0008);
        ev(3);
        tick(2);
        chk_irq(int_x, 1'b1);
        wr(8'h00, 16'hffff);
        tick(1);
        wr(8'h16, 16'h0020);
        slot_low_level_set = 12'h020;
        tick(1);
        slot_low_level_set = 12'h000;
        tick(2);
        chk_irq(int_x, 1'b1);
        wr(8'h01, 16'h0020);
        tick(2);
        chk_irq(int_x, 1'b0);
        chk_reg(16'(x_seen * 16 + y_seen), 16'h0047);
        $display("test x done");
        // Frozen cycles must take neither the event nor the mask write
        clk_en = 1'b0;
        ev(0);
        wr(8'h15, 16'h0000);
        tick(2);
        chk_irq(int_y, 1'b0);
        clk_en = 1'b1;
        tick(2);
        chk_irq(int_y, 1'b0);
        rd(8'h15);
        chk_reg(d, 16'h8001);
        $display("test freeze done");
        slot_ready_set = 12'h001;
        wr(8'h00, 16'h0001);
        slot_ready_set = 12'h000;
        tick(2);
        chk_irq(int_y, 1'b1);
        wr(8'h00, 16'h0001);
        tick(2);
        chk_irq(int_y, 1'b0);
        $display("test set wins done");
        wr(8'h07, 16'h0000);
        ev(15);
        fifo_read = 1'b1;
        tick(1);
        fifo_read = 1'b0;
        tick(2);
        chk_irq(int_y, 1'b1);
        wr(8'h00, 16'h8000);
        tick(2);
        chk_irq(int_y, 1'b0);
        $display("test autoclear off done");
        end_of_test;
    end
endmodule

// ### logic/dioe_irq_router.sv
// Status flags, enable masks and the two interrupt outputs X and Y
`timescale 1ns/1ps

// Contract
// - Y mask bit 15 gates the FIFO threshold flag onto output Y.
// - Y mask bit 14 gates the FIFO underrun flag onto output Y.
// - Y mask bit 13 gates FIFO overrun onto Y; bit 12 reserved, read-only.
// - Y mask bits 11..0 gate slot L..A data-ready flags onto output Y.
// - X mask bits 15..13 and 11..0 gate the FIFO and slot L..A data-ready flags onto output X.
// - X low-level mask bits 11..0 gate slots L..A; bits 15..12 read zero.
// - All mask enable bits are read/write and reset to zero.
// - Low-level flags set on data update, cleared by writing one.
// - With autoclear enabled (reset one), each FIFO read clears the threshold flag.
module dioe_irq_router (
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    input  wire logic                          clk_en,
    input  wire logic [dioe_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [dioe_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [dioe_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic [dioe_pkg::SLOTS-1:0]    slot_ready_set,
    input  wire logic [dioe_pkg::SLOTS-1:0]    slot_low_level_set,
    input  wire logic                          fifo_threshold_set,
    input  wire logic                          fifo_underrun_set,
    input  wire logic                          fifo_overrun_set,
    input  wire logic                          fifo_read,
    output logic                               int_x,
    output logic                               int_y
);

    function automatic logic reg_hit(input logic [dioe_pkg::ADDR_W-1:0] addr,
                                     input logic [dioe_pkg::ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction

    // One pending test for every flag/mask pair keeps X and Y decoding identical
    function automatic logic any_pending(input logic [dioe_pkg::DATA_W-1:0] flags,
                                         input logic [dioe_pkg::DATA_W-1:0] mask);
        any_pending = |(flags & mask);
    endfunction

    logic [dioe_pkg::DATA_W-1:0] irq_x_slot_fifo_mask_reg_q;
    logic [dioe_pkg::DATA_W-1:0] irq_y_slot_fifo_mask_reg_q;
    logic [dioe_pkg::DATA_W-1:0] irq_x_low_level_mask_reg_q;
    logic [dioe_pkg::DATA_W-1:0] autoclear_q;
    logic [dioe_pkg::DATA_W-1:0] fifo_slot_flag_q;
    logic [dioe_pkg::DATA_W-1:0] low_level_flag_q;
    logic [dioe_pkg::DATA_W-1:0] fifo_slot_set;
    logic [dioe_pkg::DATA_W-1:0] fifo_slot_clr;
    logic [dioe_pkg::DATA_W-1:0] low_level_set;
    logic [dioe_pkg::DATA_W-1:0] low_level_clr;
    logic [dioe_pkg::DATA_W-1:0] rdata_d;
    logic [dioe_pkg::DATA_W-1:0] rdata_q;
    logic                        int_x_d;
    logic                        int_x_q;
    logic                        int_y_d;
    logic                        int_y_q;
    logic                        fifo_autoclear;
    logic                        wr_go;
    logic                        rd_take;
    logic                        wr_x_mask;
    logic                        wr_y_mask;
    logic                        wr_xl_mask;
    logic                        wr_autoclear;
    logic                        wr_fifo_status;
    logic                        wr_low_status;

    // The clock enable is folded into each strobe once, so a frozen cycle takes nothing
    assign wr_go          = clk_en && reg_wr;
    assign rd_take        = clk_en && reg_rd;
    assign wr_x_mask      = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_X_SLOT_FIFO_MASK);
    assign wr_y_mask      = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_Y_SLOT_FIFO_MASK);
    assign wr_xl_mask     = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_X_LOW_LEVEL_MASK);
    assign wr_autoclear   = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_AUTOCLEAR);
    assign wr_fifo_status = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_FIFO_SLOT_STATUS);
    assign wr_low_status  = wr_go && reg_hit(reg_addr, dioe_pkg::OFF_LOW_LEVEL_STATUS);

    // Mask registers; reserved bits are never stored
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_x_slot_fifo_mask_reg_q <= dioe_pkg::MASK_RESET;
        end else if (wr_x_mask) begin
            irq_x_slot_fifo_mask_reg_q <= reg_wdata & dioe_pkg::FIFO_SLOT_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_y_slot_fifo_mask_reg_q <= dioe_pkg::MASK_RESET;
        end else if (wr_y_mask) begin
            // Bit 12 stays zero
            irq_y_slot_fifo_mask_reg_q <= reg_wdata & dioe_pkg::FIFO_SLOT_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_x_low_level_mask_reg_q <= dioe_pkg::MASK_RESET;
        end else if (wr_xl_mask) begin
            irq_x_low_level_mask_reg_q <= reg_wdata & dioe_pkg::LOW_LEVEL_WMASK;
        end
    end

    // Only the FIFO threshold autoclear is kept; the per-slot enables read as zero
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            autoclear_q <= dioe_pkg::AUTOCLEAR_RESET;
        end else if (wr_autoclear) begin
            autoclear_q <= reg_wdata & dioe_pkg::AUTOCLEAR_WMASK;
        end
    end

    assign fifo_autoclear = fifo_read && autoclear_q[dioe_pkg::BIT_AUTOCLEAR_FIFO];

    always_comb begin
        fifo_slot_set = {fifo_threshold_set, fifo_underrun_set, fifo_overrun_set, 1'b0,
                         slot_ready_set};
        low_level_set = {4'h0, slot_low_level_set};
        fifo_slot_clr = '0;
        low_level_clr = '0;
        if (wr_fifo_status) begin
            fifo_slot_clr = reg_wdata & dioe_pkg::FIFO_SLOT_WMASK;
        end
        if (wr_low_status) begin
            low_level_clr = reg_wdata & dioe_pkg::LOW_LEVEL_WMASK;
        end
        if (fifo_autoclear) begin
            fifo_slot_clr[dioe_pkg::BIT_FIFO_THRESHOLD] = 1'b1;
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins, so no event is lost
    // Bit 12 and the top four low-level bits are never set and keep their reset zero
    genvar g;
    generate
        for (g = 0; g < dioe_pkg::DATA_W; g++) begin : g_flag
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    fifo_slot_flag_q[g] <= dioe_pkg::STATUS_RESET[g];
                end else if (clk_en) begin
                    if (fifo_slot_set[g]) begin
                        fifo_slot_flag_q[g] <= 1'b1;
                    end else if (fifo_slot_clr[g]) begin
                        fifo_slot_flag_q[g] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    low_level_flag_q[g] <= dioe_pkg::STATUS_RESET[g];
                end else if (clk_en) begin
                    if (low_level_set[g]) begin
                        low_level_flag_q[g] <= 1'b1;
                    end else if (low_level_clr[g]) begin
                        low_level_flag_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Outputs follow the flags one cycle later, so the pins never glitch on decode
    always_comb begin
        int_y_d = any_pending(fifo_slot_flag_q,
                              irq_y_slot_fifo_mask_reg_q);
        int_x_d = any_pending(fifo_slot_flag_q, irq_x_slot_fifo_mask_reg_q)
                | any_pending(low_level_flag_q, irq_x_low_level_mask_reg_q);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            int_x_q <= 1'b0;
        end else if (clk_en) begin
            int_x_q <= int_x_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            int_y_q <= 1'b0;
        end else if (clk_en) begin
            int_y_q <= int_y_d;
        end
    end

    always_comb begin
        if (reg_hit(reg_addr, dioe_pkg::OFF_FIFO_SLOT_STATUS)) begin
            rdata_d = fifo_slot_flag_q;
        end else if (reg_hit(reg_addr, dioe_pkg::OFF_LOW_LEVEL_STATUS)) begin
            rdata_d = low_level_flag_q;
        end else if (reg_hit(reg_addr, dioe_pkg::OFF_AUTOCLEAR)) begin
            rdata_d = autoclear_q;
        end else if (reg_hit(reg_addr, dioe_pkg::OFF_X_SLOT_FIFO_MASK)) begin
            rdata_d = irq_x_slot_fifo_mask_reg_q;
        end else if (reg_hit(reg_addr, dioe_pkg::OFF_Y_SLOT_FIFO_MASK)) begin
            rdata_d = irq_y_slot_fifo_mask_reg_q;
        end else if (reg_hit(reg_addr, dioe_pkg::OFF_X_LOW_LEVEL_MASK)) begin
            rdata_d = irq_x_low_level_mask_reg_q;
        end else begin
            rdata_d = dioe_pkg::READ_ZERO;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_q <= dioe_pkg::READ_ZERO;
        end else if (rd_take) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign int_x     = int_x_q;
    assign int_y     = int_y_q;

endmodule

// ### shared/dioe_pkg.sv
// Register map, field layout and reset values for the dual interrupt output enable block
package dioe_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SLOTS  = 12;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_FIFO_SLOT_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LOW_LEVEL_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_AUTOCLEAR        = 8'h07;
    localparam logic [ADDR_W-1:0] OFF_X_SLOT_FIFO_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_Y_SLOT_FIFO_MASK = 8'h15;
    localparam logic [ADDR_W-1:0] OFF_X_LOW_LEVEL_MASK = 8'h16;

    // Field positions in the FIFO/slot layout
    localparam int unsigned BIT_FIFO_THRESHOLD = 15;
    localparam int unsigned BIT_FIFO_UNDERRUN  = 14;
    localparam int unsigned BIT_FIFO_OVERRUN   = 13;
    localparam int unsigned BIT_RESERVED       = 12;
    localparam int unsigned BIT_AUTOCLEAR_FIFO = 15;

    // Writable bits: reserved positions always read zero
    localparam logic [DATA_W-1:0] FIFO_SLOT_WMASK = 16'hefff;
    localparam logic [DATA_W-1:0] LOW_LEVEL_WMASK = 16'h0fff;
    localparam logic [DATA_W-1:0] AUTOCLEAR_WMASK = 16'h8000;

    // Reset values
    localparam logic [DATA_W-1:0] MASK_RESET      = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] AUTOCLEAR_RESET = 16'h8000;
    localparam logic [DATA_W-1:0] READ_ZERO       = 16'h0000;
endpackage
